// File: mcgc_top.sv
// mcgc_top.sv: master clock control register, gating and pll sequencing
// assumes an avalon-mm master on core_clk_in at 10 MHz and an async low reset
// How it works
// [RULE1] pll ratio equals count times two plus four
// [RULE2] software writes count only from one to seven
// [RULE3] software picks count from crystal frequency table
// [RULE4] eight-bit control register, reset value 0x0A
// [RULE5] multiplier count resets to two
// [RULE6] fast oscillator disable stops oscillator and pll
// [RULE7] keypad disable stops keypad clock
// [RULE8] card disable stops card logic clock
// [RULE9] usb disable stops usb logic clock
// [RULE10] slow disable selects main-derived 32 kHz clock
// [RULE11] software sets slow disable without 32 kHz crystal
// [RULE12] power-down keeps oscillator bit, stops oscillator
// [RULE13] power-down keeps gate bits, stops three functions
// [RULE14] card detect interrupt logic always runs
// [RULE15] slow oscillator bit ignores power-down
// [RULE16] cpu clock defaults to 3.6923 MHz
// [RULE17] software enters power-down via misc bit only
// [RULE18] misc bit seven places device in power-down
// [RULE19] control register reads back last written value
`timescale 1ns/100ps
`include "mcgc_consts.svh"
module mcgc_top
    import mcgc_pkg::*;
#(
    parameter int LOCK_CYC = `MCGC_LOCK_CYC
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // avalon-mm slave
    input wire logic [`MCGC_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [1:0] avs_response_out,
    // clock tree controls
    output logic osc_run_out,
    output logic pll_locked_out,
    output logic [4:0] pll_ratio_out,
    output logic keypad_run_out,
    output logic card_run_out,
    output logic usb_run_out,
    output logic slow_osc_run_out,
    output logic rtc_from_main_out,
    output logic card_detect_run_out,
    output logic [7:0] cpu_div_out,
    output logic power_down_out
);
    // stored registers
    mcgc_mclk_t mclk_q;
    logic [7:0] misc_q;
    logic [7:0] cpudiv_q;
    // bus answer state
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;
    logic waitreq_q; // registered waitrequest, high while no answer stands
    // pll sequencer
    mcgc_pll_t pll_q;
    mcgc_pll_t pll_d;
    logic pll_locked_q; // registered lock flag, so the port comes from a flop
    logic [15:0] lock_cnt_q;
    logic [4:0] ratio_q;
    logic [2:0] ratio_seen_q;
    logic osc_run_q;
    logic slow_run_q;
    logic rtc_main_q;
    // gated enables from the cells
    logic keypad_run;
    logic card_run;
    logic usb_run;
    logic power_down_request;
    logic req;
    logic wr_fire;
    logic [31:0] rd_word;
    logic addr_ok;

    assign power_down_request = misc_q[`MCGC_POWER_DOWN_REQUEST_BIT];
    assign req = (avs_read_in || avs_write_in) && !ack_q;
    // a write lands only at the answer edge, when the master sees waitrequest low
    assign wr_fire = avs_write_in && ack_q && avs_byteenable_in[0];

    // address decode and read mux
    always_comb begin
        addr_ok = 1'b1;
        rd_word = 32'h0000_0000;
        case (avs_address_in)
            `MCGC_MCLK_ADDR: rd_word = {24'h000000, mclk_q}; // RULE19
            `MCGC_MISC_ADDR: rd_word = {24'h000000, misc_q};
            `MCGC_CPUDIV_ADDR: rd_word = {24'h000000, cpudiv_q};
            `MCGC_STAT_ADDR: rd_word = {24'h000000, 6'h00, pll_q};
            default: addr_ok = 1'b0;
        endcase
    end

    // one wait cycle, answer on the second edge of each request
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_q <= 1'b0;
            waitreq_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            resp_q <= 2'h0;
        end else begin
            ack_q <= req;
            waitreq_q <= !req;
            if (req) begin
                rdata_q <= avs_read_in ? rd_word : 32'h0000_0000;
                // unmapped addresses answer decodeerror and read zero
                resp_q <= addr_ok ? 2'h0 : 2'h3;
            end
        end
    end

    // waitrequest high until the answer cycle
    always_comb begin
        avs_waitrequest_out = waitreq_q;
        avs_readdata_out = rdata_q;
        avs_response_out = resp_q;
    end

    // master clock control register
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mclk_q <= mcgc_mclk_t'(`MCGC_MCLK_RST); // RULE4 RULE5
        end else if (wr_fire && avs_address_in == `MCGC_MCLK_ADDR) begin
            // power-down never alters the stored bits
            mclk_q <= mcgc_mclk_t'(avs_writedata_in[7:0]); // RULE19 RULE12 RULE13
        end
    end

    // misc control, only the power-down bit is kept here
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            misc_q <= `MCGC_MISC_RST;
        end else if (wr_fire && avs_address_in == `MCGC_MISC_ADDR) begin
            misc_q <= {avs_writedata_in[7], 7'h00}; // RULE18
        end
    end

    // cpu clock divider, default gives 3.6923 MHz from 96 MHz
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cpudiv_q <= `MCGC_CPUDIV_RST; // RULE16
        end else if (wr_fire && avs_address_in == `MCGC_CPUDIV_ADDR) begin
            cpudiv_q <= avs_writedata_in[7:0];
        end
    end

    // pll ratio; out-of-range counts are passed on as written
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ratio_q <= 5'h08;
            ratio_seen_q <= `MCGC_MULT_RST;
        end else begin
            ratio_q <= 5'({mclk_q.pll_multiplier_field, 1'b0}) + `MCGC_MULT_BASE; // RULE1
            ratio_seen_q <= mclk_q.pll_multiplier_field;
        end
    end

    // oscillator runs unless the bit or power-down stops it
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            osc_run_q <= 1'b0;
        end else begin
            osc_run_q <= !mclk_q.fast_osc_disable && !power_down_request; // RULE6 RULE12
        end
    end

    // slow oscillator follows its own bit only
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            slow_run_q <= 1'b0;
            rtc_main_q <= 1'b0;
        end else begin
            slow_run_q <= !mclk_q.slow_osc_disable; // RULE10 RULE15
            rtc_main_q <= mclk_q.slow_osc_disable; // RULE10
        end
    end

    // pll must re-settle after an oscillator stop or ratio change
    always_comb begin
        pll_d = pll_q;
        case (pll_q)
            MCGC_PLL_OFF: if (osc_run_q) pll_d = MCGC_PLL_SETTLE;
            MCGC_PLL_SETTLE: begin
                if (!osc_run_q) begin
                    pll_d = MCGC_PLL_OFF;
                end else if (lock_cnt_q >= 16'(LOCK_CYC - 1)) begin
                    pll_d = MCGC_PLL_LOCKED;
                end
            end
            MCGC_PLL_LOCKED: begin
                if (!osc_run_q) begin
                    pll_d = MCGC_PLL_OFF;
                end else if (ratio_seen_q != mclk_q.pll_multiplier_field) begin
                    pll_d = MCGC_PLL_SETTLE;
                end
            end
            default: pll_d = MCGC_PLL_OFF;
        endcase
    end

    // pll state register
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pll_q <= MCGC_PLL_OFF;
            pll_locked_q <= 1'b0;
        end else begin
            pll_q <= pll_d; // RULE6
            pll_locked_q <= (pll_d == MCGC_PLL_LOCKED); // RULE6
        end
    end

    // settle counter restarts on every entry to settle
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lock_cnt_q <= 16'h0000;
        end else if (pll_q == MCGC_PLL_SETTLE && pll_d == MCGC_PLL_SETTLE) begin
            lock_cnt_q <= lock_cnt_q + 16'h0001;
        end else begin
            lock_cnt_q <= 16'h0000;
        end
    end

    // three function gates share one cell design
    mcgc_gate_cell u_keypad (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .disable_in(mclk_q.keypad_clock_disable), // RULE7
        .power_down_request_in(power_down_request), // RULE13
        .run_out(keypad_run)
    );
    mcgc_gate_cell u_card (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .disable_in(mclk_q.card_clock_disable), // RULE8
        .power_down_request_in(power_down_request), // RULE13
        .run_out(card_run)
    );
    mcgc_gate_cell u_usb (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .disable_in(mclk_q.usb_logic_clock_disable), // RULE9
        .power_down_request_in(power_down_request), // RULE13
        .run_out(usb_run)
    );

    // outputs straight from flip-flops, except card detect, which is tied high
    always_comb begin
        osc_run_out = osc_run_q;
        pll_locked_out = pll_locked_q;
        pll_ratio_out = ratio_q;
        keypad_run_out = keypad_run;
        card_run_out = card_run;
        usb_run_out = usb_run;
        slow_osc_run_out = slow_run_q;
        rtc_from_main_out = rtc_main_q;
        card_detect_run_out = 1'b1; // RULE14
        cpu_div_out = cpudiv_q;
        power_down_out = power_down_request;
    end

    // assertions
    property p_ratio;
        @(posedge core_clk_in) disable iff (!rstn_in)
        ##1 $stable(mclk_q) |=> pll_ratio_out == 5'({$past(mclk_q.pll_multiplier_field, 2), 1'b0}) + 5'h04;
    endproperty
    a_ratio: assert property (p_ratio) else $error("pll ratio wrong"); // RULE1

    property p_reset_val;
        @(posedge core_clk_in) $rose(rstn_in) |-> mclk_q == 8'h0A && mclk_q.pll_multiplier_field == 3'h2;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad reset value"); // RULE4

    property p_osc_stop;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (mclk_q.fast_osc_disable || power_down_request) |=> !osc_run_out ##1 !pll_locked_out;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped"); // RULE6

    property p_keypad;
        @(posedge core_clk_in) disable iff (!rstn_in)
        mclk_q.keypad_clock_disable |=> !keypad_run_out;
    endproperty
    a_keypad: assert property (p_keypad) else $error("keypad clock running"); // RULE7

    property p_card;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (mclk_q.card_clock_disable || power_down_request) |=> !card_run_out && card_detect_run_out;
    endproperty
    a_card: assert property (p_card) else $error("card gate wrong"); // RULE8

    property p_usb;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (!mclk_q.usb_logic_clock_disable && !power_down_request) |=> usb_run_out;
    endproperty
    a_usb: assert property (p_usb) else $error("usb clock stopped"); // RULE9

    property p_slow;
        @(posedge core_clk_in) disable iff (!rstn_in)
        ##1 1'b1 |-> rtc_from_main_out == $past(mclk_q.slow_osc_disable) && slow_osc_run_out != rtc_from_main_out;
    endproperty
    a_slow: assert property (p_slow) else $error("slow osc select wrong"); // RULE10

    property p_power_down_request_keep;
        @(posedge core_clk_in) disable iff (!rstn_in)
        !(wr_fire && avs_address_in == `MCGC_MCLK_ADDR) |=> $stable(mclk_q);
    endproperty
    a_power_down_request_keep: assert property (p_power_down_request_keep) else $error("register changed"); // RULE13

    property p_readback;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (avs_read_in && !ack_q && avs_address_in == `MCGC_MCLK_ADDR) |=> avs_readdata_out[7:0] == $past(mclk_q);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch"); // RULE19

    c_power_down_request: cover property (@(posedge core_clk_in) disable iff (!rstn_in) $rose(power_down_request));
    c_lock: cover property (@(posedge core_clk_in) disable iff (!rstn_in) $rose(pll_locked_out));
    c_write: cover property (@(posedge core_clk_in) disable iff (!rstn_in) wr_fire);
endmodule // mcgc_top

// File: mcgc_consts.svh
// mcgc_consts.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package and design files
`ifndef MCGC_CONSTS_SVH
`define MCGC_CONSTS_SVH

// register byte addresses (index times four)
`define MCGC_MCLK_IDX 8'h8F
`define MCGC_MCLK_ADDR 18'h0023C
`define MCGC_MISC_IDX 16'hFFF1
`define MCGC_MISC_ADDR 18'h3FFC4
`define MCGC_CPUDIV_ADDR 18'h00400
`define MCGC_STAT_ADDR 18'h00404
`define MCGC_ADDR_W 18

// field positions of master_clock_control and of the misc power-down bit
`define MCGC_FAST_OSC_BIT 7
`define MCGC_KEYPAD_BIT 6
`define MCGC_CARD_BIT 5
`define MCGC_USB_BIT 4
`define MCGC_SLOW_OSC_BIT 3
`define MCGC_POWER_DOWN_REQUEST_BIT 7

// reset values
`define MCGC_MCLK_RST 8'h0A
`define MCGC_MISC_RST 8'h00
`define MCGC_MULT_RST 3'h2
// cpu divider reset: 96 MHz / 26 = 3.6923 MHz
`define MCGC_CPUDIV_RST 8'h1A

// pll multiply ratio: count*2 + 4
`define MCGC_MULT_BASE 5'h04
// pll settle time in ns and its count at a 100 ns clock period
`define MCGC_LOCK_NS 2000
`define MCGC_CLK_NS 100
`define MCGC_LOCK_CYC ((`MCGC_LOCK_NS + `MCGC_CLK_NS - 1) / `MCGC_CLK_NS)

`endif

// File: mcgc_pkg.sv
// mcgc_pkg.sv: types shared by the clock control design files
// assumes mcgc_consts.svh is on the include path
package mcgc_pkg;
    `include "mcgc_consts.svh"

    // decoded master clock control fields
    typedef struct packed {
        logic fast_osc_disable;
        logic keypad_clock_disable;
        logic card_clock_disable;
        logic usb_logic_clock_disable;
        logic slow_osc_disable;
        logic [2:0] pll_multiplier_field;
    } mcgc_mclk_t;

    // gate enables sent to the clock tree
    typedef struct packed {
        logic osc_run;
        logic keypad_run;
        logic card_run;
        logic usb_run;
        logic slow_osc_run;
        logic rtc_from_main;
    } mcgc_gate_t;

    // pll sequencing states
    typedef enum logic [1:0] {
        MCGC_PLL_OFF = 2'b00,
        MCGC_PLL_SETTLE = 2'b01,
        MCGC_PLL_LOCKED = 2'b10
    } mcgc_pll_t;
endpackage

// File: mcgc_gate_cell.sv
// mcgc_gate_cell.sv: one registered clock enable with power-down override
// assumes disable_in and power_down_request_in come from the same clock domain
`timescale 1ns/100ps
module mcgc_gate_cell (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // control
    input wire logic disable_in,
    input wire logic power_down_request_in,
    // gated enable
    output logic run_out
);
    // run only when neither the bit nor power-down stops the function
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_out <= 1'b0;
        end else begin
            run_out <= !disable_in && !power_down_request_in;
        end
    end
endmodule // mcgc_gate_cell

// File: mcgc_top_test.sv
// mcgc_top_test.sv: self-checking bench for the master clock control block
// assumes mcgc_pkg and mcgc_top are compiled first and the consts header is on the include path
`timescale 1ns/100ps
`include "mcgc_consts.svh"
module mcgc_top_test;
    import mcgc_pkg::*;
    localparam int LOCK = 3; // short settle time keeps the run brief
    localparam logic [17:0] A_MCLK = 18'(`MCGC_MCLK_ADDR);
    localparam logic [17:0] A_MISC = `MCGC_MISC_ADDR;
    localparam logic [17:0] A_CPUDIV = 18'(`MCGC_CPUDIV_ADDR);
    localparam logic [17:0] A_STAT = `MCGC_STAT_ADDR;
    localparam logic [17:0] A_BAD = 18'h00100; // nothing decodes here

    logic clk; // bench clock, 100 ns period
    logic rst_n; // async reset, active low
    logic rd; // bus read strobe
    logic wrr; // bus write strobe
    logic [17:0] adr;
    logic [31:0] wdat;
    logic [3:0] ben;
    logic [31:0] rdat;
    logic wreq;
    logic [1:0] resp;
    logic osc_run, pll_locked, keypad_run, card_run, usb_run;
    logic slow_run, rtc_main, det_run, pwr_dn;
    logic [4:0] ratio;
    logic [7:0] cpu_div;
    logic [33:0] exp_q[$]; // expected {response, readdata} per read
    int mismatches;
    int checked;
    logic [31:0] seed;

    mcgc_top #(.LOCK_CYC(LOCK)) u_mcgc_top (
        .core_clk_in(clk), .rstn_in(rst_n),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wrr),
        .avs_writedata_in(wdat), .avs_byteenable_in(ben),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .avs_response_out(resp),
        .osc_run_out(osc_run), .pll_locked_out(pll_locked), .pll_ratio_out(ratio),
        .keypad_run_out(keypad_run), .card_run_out(card_run), .usb_run_out(usb_run),
        .slow_osc_run_out(slow_run), .rtc_from_main_out(rtc_main),
        .card_detect_run_out(det_run), .cpu_div_out(cpu_div), .power_down_out(pwr_dn)
    );

    // free running clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    // fixed-seed xorshift so every run drives the same values
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // one comparison, counted, reported on mismatch
    task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    // verdict and end of run, shared with the watchdog
    task automatic print_verdict;
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // avalon master cycle: hold everything until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [17:0] a, input logic [31:0] d,
        input logic [3:0] be, input logic [33:0] e);
        @(posedge clk);
        if (!wr) begin
            exp_q.push_back(e);
        end
        adr <= a;
        wdat <= d;
        ben <= be;
        rd <= !wr;
        wrr <= wr;
        // no latency assumed; a slave that never answers is ended by the watchdog
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        rd <= 1'b0;
        wrr <= 1'b0;
    endtask

    task automatic rdc(input logic [17:0] a, input logic [7:0] v, input logic [1:0] r);
        bus(1'b0, a, 32'h0, 4'hF, {r, 24'h0, v});
    endtask

    task automatic wrt(input logic [17:0] a, input logic [7:0] v);
        bus(1'b1, a, {24'h0, v}, 4'h1, 34'h0);
    endtask

    // clock tree outputs against a stored register value and power-down state
    task automatic gates(input logic [7:0] v, input logic pd);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("osc_run", 34'(osc_run), 34'(!v[7] && !pd));
        chk("keypad_run", 34'(keypad_run), 34'(!v[6] && !pd));
        chk("card_run", 34'(card_run), 34'(!v[5] && !pd));
        chk("usb_run", 34'(usb_run), 34'(!v[4] && !pd));
        chk("slow_osc_run", 34'(slow_run), 34'(!v[3]));
        chk("rtc_from_main", 34'(rtc_main), 34'(v[3]));
        chk("pll_ratio", 34'(ratio), 34'({1'b0, v[2:0], 1'b0} + `MCGC_MULT_BASE));
        chk("card_detect", 34'(det_run), 34'h1);
        chk("power_down", 34'(pwr_dn), 34'(pd));
    endtask

    // read monitor: data taken at the edge where waitrequest is sampled low
    always @(posedge clk) begin
        if (rd === 1'b1 && wreq === 1'b0) begin
            chk("readback", {resp, rdat}, exp_q.size() > 0 ? exp_q.pop_front() : 34'hX);
        end
    end

    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #(20000 * 100);
        mismatches++;
        $display("CHECK FAILED watchdog expected done seen running");
        print_verdict();
    end

    // main sequence
    initial begin
        int n;
        logic [7:0] v;
        rst_n = 1'b0;
        rd = 1'b0;
        wrr = 1'b0;
        adr = '0;
        wdat = '0;
        ben = '0;
        mismatches = 0;
        checked = 0;
        seed = 32'h24A6;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // reset values at the ports and through the bus
        gates(`MCGC_MCLK_RST, 1'b0);
        chk("cpu_div", 34'(cpu_div), 34'(`MCGC_CPUDIV_RST));
        rdc(A_MCLK, `MCGC_MCLK_RST, 2'b00);
        rdc(A_CPUDIV, `MCGC_CPUDIV_RST, 2'b00);
        rdc(A_MISC, `MCGC_MISC_RST, 2'b00);
        // processor clock rate is set through its own register
        wrt(A_CPUDIV, 8'h0D);
        rdc(A_CPUDIV, 8'h0D, 2'b00);
        chk("cpu_div_wr", 34'(cpu_div), 34'h0D);
        // every legal count with random gate bits, back to back
        for (int c = 1; c <= 7; c++) begin
            seed = xs(seed);
            v = {seed[7:3], 3'(c)};
            wrt(A_MCLK, v);
            rdc(A_MCLK, v, 2'b00);
            gates(v, 1'b0);
        end
        // power-down overrides gates but leaves stored bits and slow oscillator alone
        wrt(A_MCLK, 8'h04);
        gates(8'h04, 1'b0);
        wrt(A_MISC, 8'hFF);
        gates(8'h04, 1'b1);
        rdc(A_MCLK, 8'h04, 2'b00);
        rdc(A_MISC, 8'h80, 2'b00);
        wrt(A_MISC, 8'h00);
        gates(8'h04, 1'b0);
        // refused accesses leave the register untouched
        rdc(A_BAD, 8'h00, 2'b11);
        bus(1'b1, A_BAD, 32'hFF, 4'hF, 34'h0);
        bus(1'b1, A_MCLK, 32'h55, 4'hE, 34'h0);
        rdc(A_MCLK, 8'h04, 2'b00);
        // oscillator off drops lock, back on relocks within a bounded wait
        wrt(A_MCLK, 8'h8A);
        repeat (LOCK + 3) @(posedge clk);
        @(negedge clk);
        chk("pll_locked_off", 34'(pll_locked), 34'h0);
        wrt(A_MCLK, 8'h0A);
        n = 0;
        while (pll_locked !== 1'b1 && n < LOCK + 10) begin
            @(negedge clk);
            n++;
        end
        chk("pll_locked_on", 34'(pll_locked), 34'h1);
        rdc(A_STAT, 8'h02, 2'b00);
        // let the read monitor take the last answer before the verdict
        @(negedge clk);
        print_verdict();
    end
endmodule // mcgc_top_test
